// File: core/asp_core.sv
`timescale 1ns/1ps
`include "asp_defs.svh"

// Behaviour
// - Read with chip select and read low, write high drives selected register.
// - Chip select rising during low write with upper select low stores low byte.
// - Write strobe rising under chip select stores low byte; else ignored.
// - Bus drivers enabled only during read condition, released when it ends.
// - Upper select returns high byte on low lines; writes then do nothing.
// - Select codes: receive status, receive buffer, transmit status, transmit buffer.
// - Start edge accepted only after line was high half a bit.
// - Inhibit low keeps programmable baud field and enable cleared.
// - Baud rates 300 to 38400 derived internally.
// - One shared baud rate, one stop bit per frame.
// - Parallel characters shifted out; serial characters assembled in.
// - Flags show transmitter ready and character received.
// - Works with 8-bit or 16-bit host data paths.
// - Detects overrun and framing errors; can force break on output.
// - Status registers readable at any time without side effects; a receive buffer read with upper select low clears the done flag.
// - Receive interrupt follows done flag while its enable is set.
// - Transmit interrupt only when ready flag and enable both set.
module asp_core #(
    parameter int unsigned BIT0_CYCLES = `ASP_CLK_HZ / `ASP_BAUD_MIN,
    parameter int unsigned RTC_HALF    = `ASP_CLK_HZ / (2 * `ASP_RTC_HZ)
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             clk_en_in,
    input  wire asp_pkg::asp_host_s host_in,
    output logic [15:0]           host_data_bus_out,
    output logic                  host_data_bus_oe_out,
    input  wire logic             serial_in,
    output logic                  serial_out,
    input  wire logic             soft_clear_in,
    input  wire logic             baud_prog_inhibit_n_in,
    input  wire logic [2:0]       baud_select_n_in,
    output logic                  tick_800hz_out,
    output logic                  rx_interrupt_out,
    output logic                  tx_interrupt_out
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SW = $bits(asp_pkg::asp_host_s) + 6;

    logic [SW-1:0]       sync1_reg;
    logic [SW-1:0]       sync2_reg;
    asp_pkg::asp_host_s  h_s;
    asp_pkg::asp_host_s  h_d_reg;
    logic                si_s;
    logic                clr_s;
    logic                inh_n_s;
    logic [2:0]          brs_n_s;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            h_d_reg   <= '1;
        end else if (clk_en_in) begin
            sync1_reg <= {host_in, serial_in, soft_clear_in,
                          baud_prog_inhibit_n_in, baud_select_n_in};
            sync2_reg <= sync1_reg;
            h_d_reg   <= h_s;
        end
    end

    assign {h_s, si_s, clr_s, inh_n_s, brs_n_s} = sync2_reg;

    // ****************************************
    // Host strobes
    // ****************************************
    logic rd_act;
    logic rd_act_d;
    logic wr_act;
    logic wr_act_d;
    logic wr_fire;
    logic rx_buffer_read;

    assign rd_act   = !h_s.cs_n && !h_s.rd_n && h_s.low_byte_write_n;
    assign rd_act_d = !h_d_reg.cs_n && !h_d_reg.rd_n && h_d_reg.low_byte_write_n;
    assign wr_act   = !h_s.cs_n && !h_s.low_byte_write_n;
    assign wr_act_d = !h_d_reg.cs_n && !h_d_reg.low_byte_write_n;
    // Either strobe rising ends the write; upper select blocks it
    assign wr_fire  = wr_act_d && !wr_act && !h_d_reg.upper_byte_select;
    assign rx_buffer_read = rd_act_d && !rd_act &&
                       h_d_reg.register_select == `ASP_SEL_RX_BUFFER &&
                       !h_d_reg.upper_byte_select;

    // ****************************************
    // Control bits
    // ****************************************
    logic       rx_ie_reg;
    logic       tx_ie_reg;
    logic       loop_reg;
    logic       brk_reg;
    logic [2:0] pbr_reg;
    logic       baud_prog_enable_reg;
    logic [7:0] tx_buf_reg;
    logic       tx_ready_reg;
    logic       tx_load;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_ie_reg    <= 1'b0;
            tx_ie_reg    <= 1'b0;
            loop_reg     <= 1'b0;
            brk_reg      <= 1'b0;
            pbr_reg      <= 3'h0;
            baud_prog_enable_reg     <= 1'b0;
            tx_buf_reg   <= 8'h00;
            tx_ready_reg <= 1'b1;
        end else if (clk_en_in) begin
            if (wr_fire) begin
                unique case (h_d_reg.register_select)
                    `ASP_SEL_RX_CONTROL_STATUS: rx_ie_reg <= h_d_reg.host_data_bus[`ASP_RC_IE];
                    `ASP_SEL_RX_BUFFER: ;
                    `ASP_SEL_TX_CONTROL_STATUS: begin
                        tx_ie_reg <= h_d_reg.host_data_bus[`ASP_XC_IE];
                        pbr_reg   <= h_d_reg.host_data_bus[`ASP_XC_PBR_HI:`ASP_XC_PBR_LO];
                        loop_reg  <= h_d_reg.host_data_bus[`ASP_XC_LOOP];
                        baud_prog_enable_reg  <= h_d_reg.host_data_bus[`ASP_XC_BAUD_PROG_ENABLE];
                        brk_reg   <= h_d_reg.host_data_bus[`ASP_XC_BRK];
                    end
                    `ASP_SEL_TX_BUFFER: begin
                        tx_buf_reg   <= h_d_reg.host_data_bus[7:0];
                        tx_ready_reg <= 1'b0;
                    end
                endcase
            end else if (tx_load) begin
                tx_ready_reg <= 1'b1;
            end
            if (clr_s) begin
                rx_ie_reg <= 1'b0;
                tx_ie_reg <= 1'b0;
                loop_reg  <= 1'b0;
                brk_reg   <= 1'b0;
            end
            if (!inh_n_s) begin
                pbr_reg  <= 3'h0;
                baud_prog_enable_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Shared baud timing
    // ****************************************
    logic [2:0]  baud_code;
    logic [17:0] bit_cyc;
    logic [17:0] half_cyc;

    assign baud_code = baud_prog_enable_reg ? pbr_reg : ~brs_n_s;
    assign bit_cyc   = 18'(BIT0_CYCLES >> baud_code);
    assign half_cyc  = bit_cyc >> 1;

    // ****************************************
    // Receiver
    // ****************************************
    asp_pkg::asp_rx_state_e rx_state_reg;
    logic [17:0] rx_cnt_reg;
    logic [17:0] mark_cnt_reg;
    logic [3:0]  rx_bit_reg;
    logic [7:0]  rx_sh_reg;
    logic [7:0]  rx_data_reg;
    logic        rx_done_reg;
    logic        rx_act_reg;
    logic        ovr_reg;
    logic        frm_reg;
    logic        rbrk_reg;
    logic        line_prev_reg;
    logic        so_reg;
    logic        rx_line;
    logic        armed;
    logic        rx_store;

    assign rx_line = loop_reg ? so_reg : si_s;
    assign armed   = mark_cnt_reg >= half_cyc;
    assign rx_store = rx_state_reg == asp_pkg::ASP_RX_DATA &&
                      rx_cnt_reg == bit_cyc - 18'h1 && rx_bit_reg == `ASP_DATA_BITS;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mark_cnt_reg  <= 18'h0;
            line_prev_reg <= 1'b1;
        end else if (clk_en_in) begin
            line_prev_reg <= rx_line;
            if (!rx_line) begin
                mark_cnt_reg <= 18'h0;
            end else if (!armed) begin
                mark_cnt_reg <= mark_cnt_reg + 18'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_state_reg <= asp_pkg::ASP_RX_IDLE;
            rx_cnt_reg   <= 18'h0;
            rx_bit_reg   <= 4'h0;
            rx_sh_reg    <= 8'h00;
            rx_act_reg   <= 1'b0;
        end else if (clk_en_in) begin
            unique case (rx_state_reg)
                asp_pkg::ASP_RX_IDLE: begin
                    rx_cnt_reg <= 18'h0;
                    if (armed && line_prev_reg && !rx_line) begin
                        rx_state_reg <= asp_pkg::ASP_RX_START;
                    end
                end
                asp_pkg::ASP_RX_START: begin
                    rx_cnt_reg <= rx_cnt_reg + 18'h1;
                    if (rx_cnt_reg == half_cyc - 18'h1) begin
                        rx_cnt_reg <= 18'h0;
                        rx_bit_reg <= 4'h0;
                        if (!rx_line) begin
                            rx_state_reg <= asp_pkg::ASP_RX_DATA;
                            rx_act_reg   <= 1'b1;
                        end else begin
                            rx_state_reg <= asp_pkg::ASP_RX_IDLE;
                        end
                    end
                end
                asp_pkg::ASP_RX_DATA: begin
                    rx_cnt_reg <= rx_cnt_reg + 18'h1;
                    if (rx_cnt_reg == bit_cyc - 18'h1) begin
                        rx_cnt_reg <= 18'h0;
                        if (rx_bit_reg != `ASP_DATA_BITS) begin
                            rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg == `ASP_DATA_BITS - 4'h1) begin
                                rx_act_reg <= 1'b0;
                            end
                        end else begin
                            rx_state_reg <= asp_pkg::ASP_RX_IDLE;
                        end
                    end
                end
                default: rx_state_reg <= asp_pkg::ASP_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_data_reg <= 8'h00;
            rx_done_reg <= 1'b0;
            ovr_reg     <= 1'b0;
            frm_reg     <= 1'b0;
            rbrk_reg    <= 1'b0;
        end else if (clk_en_in) begin
            if (rx_store) begin
                rx_data_reg <= rx_sh_reg;
                rx_done_reg <= 1'b1;
                ovr_reg     <= rx_done_reg && !rx_buffer_read;
                frm_reg     <= !rx_line;
                rbrk_reg    <= !rx_line && rx_sh_reg == 8'h00;
            end else begin
                if (rx_buffer_read) begin
                    rx_done_reg <= 1'b0;
                end
                if (rx_line) begin
                    rbrk_reg <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    asp_pkg::asp_tx_state_e tx_state_reg;
    logic [9:0]  tx_sh_reg;
    logic [17:0] tx_cnt_reg;
    logic [3:0]  tx_bit_reg;

    assign tx_load = tx_state_reg == asp_pkg::ASP_TX_IDLE && !tx_ready_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_state_reg <= asp_pkg::ASP_TX_IDLE;
            tx_sh_reg    <= 10'h3ff;
            tx_cnt_reg   <= 18'h0;
            tx_bit_reg   <= 4'h0;
            so_reg       <= 1'b1;
        end else if (clk_en_in) begin
            so_reg <= !brk_reg && tx_sh_reg[0];
            unique case (tx_state_reg)
                asp_pkg::ASP_TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg    <= {1'b1, tx_buf_reg, 1'b0};
                        tx_cnt_reg   <= 18'h0;
                        tx_bit_reg   <= 4'h0;
                        tx_state_reg <= asp_pkg::ASP_TX_RUN;
                    end
                end
                asp_pkg::ASP_TX_RUN: begin
                    tx_cnt_reg <= tx_cnt_reg + 18'h1;
                    if (tx_cnt_reg == bit_cyc - 18'h1) begin
                        tx_cnt_reg <= 18'h0;
                        tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg == `ASP_DATA_BITS + 4'h1) begin
                            tx_state_reg <= asp_pkg::ASP_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign serial_out = so_reg;

    // ****************************************
    // Read port
    // ****************************************
    logic [15:0] rd_word;

    always_comb begin
        rd_word = 16'h0000;
        unique case (h_s.register_select)
            `ASP_SEL_RX_CONTROL_STATUS: begin
                rd_word[`ASP_RC_ACT]  = rx_act_reg;
                rd_word[`ASP_RC_DONE] = rx_done_reg;
                rd_word[`ASP_RC_IE]   = rx_ie_reg;
            end
            `ASP_SEL_RX_BUFFER: begin
                rd_word[7:0]         = rx_data_reg;
                rd_word[`ASP_RB_ERR] = ovr_reg || frm_reg;
                rd_word[`ASP_RB_OVR] = ovr_reg;
                rd_word[`ASP_RB_FRM] = frm_reg;
                rd_word[`ASP_RB_BRK] = rbrk_reg;
            end
            `ASP_SEL_TX_CONTROL_STATUS: begin
                rd_word[`ASP_XC_RDY] = tx_ready_reg;
                rd_word[`ASP_XC_IE]  = tx_ie_reg;
                rd_word[`ASP_XC_PBR_HI:`ASP_XC_PBR_LO] = pbr_reg;
                rd_word[`ASP_XC_LOOP] = loop_reg;
                rd_word[`ASP_XC_BAUD_PROG_ENABLE] = baud_prog_enable_reg;
                rd_word[`ASP_XC_BRK]  = brk_reg;
            end
            `ASP_SEL_TX_BUFFER: rd_word[7:0] = tx_buf_reg;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            host_data_bus_out    <= 16'h0000;
            host_data_bus_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            host_data_bus_oe_out <= rd_act;
            if (h_s.upper_byte_select) begin
                host_data_bus_out <= {8'h00, rd_word[15:8]};
            end else begin
                host_data_bus_out <= rd_word;
            end
        end
    end

    assign rx_interrupt_out = rx_ie_reg && rx_done_reg;
    assign tx_interrupt_out = tx_ie_reg && tx_ready_reg;

    // ****************************************
    // Real-time tick
    // ****************************************
    logic [31:0] rtc_cnt_reg;
    logic        rtc_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rtc_cnt_reg <= 32'h0;
            rtc_reg     <= 1'b0;
        end else if (clk_en_in) begin
            if (rtc_cnt_reg == RTC_HALF - 1) begin
                rtc_cnt_reg <= 32'h0;
                rtc_reg     <= !rtc_reg;
            end else begin
                rtc_cnt_reg <= rtc_cnt_reg + 32'h1;
            end
        end
    end

    assign tick_800hz_out = rtc_reg;

endmodule

// File: core/asp_defs.svh
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define ASP_CLK_HZ      40000000
`define ASP_BAUD_MIN    300
`define ASP_RTC_HZ      800
`define ASP_DATA_BITS   4'h8

// ****************************************
// Register select codes
// ****************************************
`define ASP_SEL_RX_CONTROL_STATUS    2'h0
`define ASP_SEL_RX_BUFFER    2'h1
`define ASP_SEL_TX_CONTROL_STATUS    2'h2
`define ASP_SEL_TX_BUFFER    2'h3

// ****************************************
// Field positions
// ****************************************
`define ASP_RC_ACT      11
`define ASP_RC_DONE     7
`define ASP_RC_IE       6
`define ASP_RB_ERR      15
`define ASP_RB_OVR      14
`define ASP_RB_FRM      13
`define ASP_RB_BRK      11
`define ASP_XC_RDY      7
`define ASP_XC_IE       6
`define ASP_XC_PBR_HI   5
`define ASP_XC_PBR_LO   3
`define ASP_XC_LOOP     2
`define ASP_XC_BAUD_PROG_ENABLE     1
`define ASP_XC_BRK      0

`endif

// File: core/asp_pkg.sv
package asp_pkg;

    // ****************************************
    // Host port pins
    // ****************************************
    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        low_byte_write_n;
        logic        upper_byte_select;
        logic [1:0]  register_select;
        logic [15:0] host_data_bus;
    } asp_host_s;

    typedef enum logic [1:0] {
        ASP_RX_IDLE  = 2'b00,
        ASP_RX_START = 2'b01,
        ASP_RX_DATA  = 2'b10
    } asp_rx_state_e;

    typedef enum logic {
        ASP_TX_IDLE = 1'b0,
        ASP_TX_RUN  = 1'b1
    } asp_tx_state_e;

endpackage

// File: tb/asp_core_bench.sv
`timescale 1ns/1ps
module asp_core_bench;
    localparam int unsigned BIT0 = 64;
    localparam int unsigned RTC  = 10;
    typedef struct packed {
        logic [1:0]  sel;
        logic [7:0]  wd;
        logic        wup;
        logic        rup;
        logic [15:0] exp;
        logic        txi;
        logic        so;
    } asp_row_s;

    logic               clk_in;
    logic               rst_n_in;
    logic               serial_in;
    logic               soft_clear_in;
    logic               baud_prog_inhibit_n_in;
    logic [2:0]         baud_select_n_in;
    asp_pkg::asp_host_s host_in;
    logic [15:0]        host_data_bus_out;
    logic               host_data_bus_oe_out;
    logic               serial_out;
    logic               tick_800hz_out;
    logic               rx_interrupt_out;
    logic               tx_interrupt_out;
    logic [9:0]         fr;
    asp_row_s           rows [6];
    int                 num_errors;
    int                 checks;
    int                 n;
    int                 bt;

    asp_core #(.BIT0_CYCLES(BIT0), .RTC_HALF(RTC)) u_asp_core (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .host_in(host_in),
        .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_out(host_data_bus_oe_out),
        .serial_in(serial_in), .serial_out(serial_out), .soft_clear_in(soft_clear_in),
        .baud_prog_inhibit_n_in(baud_prog_inhibit_n_in), .baud_select_n_in(baud_select_n_in),
        .tick_800hz_out(tick_800hz_out), .rx_interrupt_out(rx_interrupt_out),
        .tx_interrupt_out(tx_interrupt_out));
    asp_host_model u_host (
        .clk_in(clk_in), .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe_out(host_data_bus_oe_out), .host_out(host_in));

    // ****************************************
    // Checking and stimulus tasks
    // ****************************************
    task automatic end_sim();
        $display("num_errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [1:0] sel, input logic up, input logic [15:0] exp);
        logic [15:0] q;
        logic        ok;
        u_host.rd(sel, up, q, ok);
        if (!ok) begin
            num_errors++;
            end_sim();
        end
        chk16(q, exp);
    endtask

    // Line frame: start, data low bit first, stop
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_in = f[i];
            repeat (bt) @(negedge clk_in);
        end
    endtask

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rows[0] = '{2'h2, 8'h5b, 1'b0, 1'b0, 16'h00db, 1'b1, 1'b0};
        rows[1] = '{2'h2, 8'h00, 1'b1, 1'b0, 16'h00db, 1'b1, 1'b0};
        rows[2] = '{2'h2, 8'h00, 1'b0, 1'b1, 16'h0000, 1'b0, 1'b1};
        rows[3] = '{2'h0, 8'hff, 1'b0, 1'b0, 16'h0040, 1'b0, 1'b1};
        rows[4] = '{2'h1, 8'hff, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1};
        rows[5] = '{2'h0, 8'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1};
        num_errors = 0;
        checks = 0;
        rst_n_in = 1'b0;
        serial_in = 1'b1;
        soft_clear_in = 1'b0;
        baud_prog_inhibit_n_in = 1'b1;
        baud_select_n_in = 3'h7;
        bt = BIT0;
        repeat (4) @(negedge clk_in);
        chk16({11'h0, serial_out, host_data_bus_oe_out, tick_800hz_out, rx_interrupt_out,
               tx_interrupt_out}, 16'h0010);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
        for (int i = 0; i < 6; i++) begin
            u_host.wr(rows[i].sel, rows[i].wd, rows[i].wup, i[0]);
            rdc(rows[i].sel, rows[i].rup, rows[i].exp);
            chk1(tx_interrupt_out, rows[i].txi);
            chk1(serial_out, rows[i].so);
        end
        // Soft clear also cuts a loopback break short
        u_host.wr(2'h0, 8'h40, 1'b0, 1'b0);
        u_host.wr(2'h2, 8'h5d, 1'b0, 1'b1);
        chk1(serial_out, 1'b0);
        soft_clear_in = 1'b1;
        repeat (8) @(negedge clk_in);
        soft_clear_in = 1'b0;
        rdc(2'h2, 1'b0, 16'h0098);
        rdc(2'h0, 1'b0, 16'h0000);
        u_host.wr(2'h2, 8'h1a, 1'b0, 1'b0);
        baud_prog_inhibit_n_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rdc(2'h2, 1'b0, 16'h0080);
        baud_prog_inhibit_n_in = 1'b1;
        // Transmit one character
        u_host.wr(2'h3, 8'ha5, 1'b0, 1'b1);
        n = 0;
        while (serial_out !== 1'b0 && n < 200) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            end_sim();
        end
        repeat (BIT0 / 2) @(negedge clk_in);
        for (int i = 0; i < 10; i++) begin
            fr[i] = serial_out;
            repeat (BIT0) @(negedge clk_in);
        end
        chk16({6'h00, fr}, {6'h00, 1'b1, 8'ha5, 1'b0});
        rdc(2'h2, 1'b0, 16'h0080);
        // Receive, framing with break, overrun
        u_host.wr(2'h0, 8'h40, 1'b0, 1'b0);
        send(8'h3c, 1'b1);
        chk1(rx_interrupt_out, 1'b1);
        rdc(2'h0, 1'b0, 16'h00c0);
        rdc(2'h1, 1'b0, 16'h003c);
        chk1(rx_interrupt_out, 1'b0);
        send(8'h00, 1'b0);
        rdc(2'h1, 1'b0, 16'ha800);
        serial_in = 1'b1;
        repeat (BIT0) @(negedge clk_in);
        send(8'h5a, 1'b1);
        send(8'h5a, 1'b1);
        baud_select_n_in = 3'h6;
        rdc(2'h1, 1'b0, 16'hc05a);
        // Pin-selected rate of half a slowest bit
        bt = BIT0 / 2;
        send(8'h96, 1'b1);
        rdc(2'h1, 1'b0, 16'h0096);
        end_sim();
    end
endmodule

bind asp_core asp_core_sva #(.RTC_HALF(RTC_HALF)) u_asp_core_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .host_in(host_in),
    .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_out(host_data_bus_oe_out),
    .soft_clear_in(soft_clear_in), .baud_prog_inhibit_n_in(baud_prog_inhibit_n_in),
    .tick_800hz_out(tick_800hz_out), .rx_interrupt_out(rx_interrupt_out),
    .tx_interrupt_out(tx_interrupt_out));

// File: tb/asp_core_sva.sv
`timescale 1ns/1ps
module asp_core_sva #(
    parameter int unsigned RTC_HALF = 10
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire asp_pkg::asp_host_s host_in,
    input  wire logic [15:0]        host_data_bus_out,
    input  wire logic               host_data_bus_oe_out,
    input  wire logic               soft_clear_in,
    input  wire logic               baud_prog_inhibit_n_in,
    input  wire logic               tick_800hz_out,
    input  wire logic               rx_interrupt_out,
    input  wire logic               tx_interrupt_out
);
    // ****************************************
    // Pin decode and tick counter
    // ****************************************
    logic        rd_c;
    logic        rx_buffer_c;
    logic        tx_control_status_c;
    logic        tick_q_reg;
    logic        seen_reg;
    logic [31:0] cnt_reg;

    assign rd_c   = !host_in.cs_n && !host_in.rd_n && host_in.low_byte_write_n;
    assign rx_buffer_c = rd_c && host_in.register_select == 2'h1 && !host_in.upper_byte_select;
    assign tx_control_status_c = rd_c && host_in.register_select == 2'h2 && !host_in.upper_byte_select;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_q_reg <= 1'b0;
            seen_reg   <= 1'b0;
            cnt_reg    <= 32'h0;
        end else begin
            tick_q_reg <= tick_800hz_out;
            seen_reg   <= seen_reg || (tick_800hz_out != tick_q_reg);
            cnt_reg    <= (tick_800hz_out != tick_q_reg) ? 32'h0 : cnt_reg + 32'h1;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence read_held_s;
        rd_c [*3];
    endsequence
    sequence rx_buffer_read_s;
        rx_buffer_c [*4] ##1 !rx_buffer_c;
    endsequence

    AST_OE_ON:
        assert property (read_held_s |-> ##1 host_data_bus_oe_out)
        else $error("drivers off during a read");
    AST_OE_OFF:
        assert property ((!rd_c) [*3] |-> ##1 !host_data_bus_oe_out)
        else $error("drivers on without a read");
    AST_UPPER_ZERO:
        assert property ((rd_c && host_in.upper_byte_select) [*4] |->
            host_data_bus_out[15:8] == 8'h00)
        else $error("upper lines not zero on upper byte read");
    AST_INHIBIT:
        assert property ((tx_control_status_c && !baud_prog_inhibit_n_in) [*6] |->
            host_data_bus_out[5:3] == 3'h0 && !host_data_bus_out[1])
        else $error("baud field kept while inhibited");
    AST_SOFT_CLR:
        assert property (soft_clear_in [*4] |-> ##1 (!rx_interrupt_out && !tx_interrupt_out))
        else $error("interrupt left on by soft clear");
    AST_RX_BUFFER_CLR:
        assert property (rx_buffer_read_s |-> ##[1:4] !rx_interrupt_out)
        else $error("receive interrupt kept after buffer read");
    AST_TICK_HALF:
        assert property ((tick_800hz_out != tick_q_reg) && seen_reg |-> cnt_reg == RTC_HALF - 1)
        else $error("tick half period wrong");
    AST_TICK_LIMIT:
        assert property (cnt_reg <= RTC_HALF)
        else $error("tick stalled");
endmodule

// File: tb/asp_host_model.sv
`timescale 1ns/1ps
module asp_host_model (
    input  wire logic          clk_in,
    input  wire logic [15:0]   host_data_bus_out,
    input  wire logic          host_data_bus_oe_out,
    output asp_pkg::asp_host_s host_out
);
    // ****************************************
    // Host bus cycles
    // ****************************************
    asp_pkg::asp_host_s drv;

    // Device drivers win the shared lines while enabled
    assign host_out = host_data_bus_oe_out ? {drv[21:16], host_data_bus_out} : drv;
    initial drv = {3'b111, 1'b0, 2'h0, 16'h0000};

    task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic up,
                      input logic by_cs);
        @(negedge clk_in);
        drv = {3'b010, up, sel, 8'h00, d};
        repeat (5) @(negedge clk_in);
        if (by_cs) begin
            drv.cs_n = 1'b1;
        end else begin
            drv.low_byte_write_n = 1'b1;
        end
        @(negedge clk_in);
        // Decode deselects; released lines show a changed level
        drv = {3'b111, up, sel, ~drv.host_data_bus};
        repeat (5) @(negedge clk_in);
    endtask

    task automatic rd(input logic [1:0] sel, input logic up, output logic [15:0] q,
                      output logic ok);
        int n;
        n = 0;
        @(negedge clk_in);
        drv = {3'b001, up, sel, drv.host_data_bus};
        while (host_data_bus_oe_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        repeat (4) @(negedge clk_in);
        q = host_data_bus_out;
        ok = (n < 20);
        drv = {3'b111, up, sel, ~drv.host_data_bus};
        repeat (5) @(negedge clk_in);
    endtask
endmodule
